/* File: verilog/pcp_pkg.sv */
// Constants shared by the socket power and interrupt control block
`default_nettype none
package pcp_pkg;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [11:0] PCP_OFS_IDENT = 12'h800;
  localparam logic [11:0] PCP_OFS_IFSTAT = 12'h801;
  localparam logic [11:0] PCP_OFS_PWR = 12'h802;
  localparam logic [11:0] PCP_OFS_IGC = 12'h803;

  // ****************************************
  // Reset values and revision codes
  // ****************************************
  localparam logic [7:0] PCP_PWR_RESET = 8'h00;
  localparam logic [7:0] PCP_IGC_RESET = 8'h00;
  localparam logic [3:0] PCP_REV_RESET = 4'h4;
  localparam logic [3:0] PCP_REV_ORIGINAL = 4'h2;
  localparam logic [1:0] PCP_IFTYPE = 2'h2;
  localparam logic [1:0] PCP_IDSPARE_RESET = 2'h0;

  // ****************************************
  // Power register layouts
  // ****************************************
  localparam logic [7:0] PCP_PWR_MASK_ORIG = 8'hb3;
  localparam logic [7:0] PCP_PWR_MASK_REV = 8'h9b;
  localparam logic [7:0] PCP_PWR_CTX_ORIG = 8'ha0;
  localparam logic [7:0] PCP_PWR_CTX_REV = 8'h9b;
  localparam int PCP_PWR_OE_BIT = 7;
  localparam int PCP_PWR_AUTO_BIT = 5;
  localparam int PCP_PWR_SUPPLY_BIT = 4;
  localparam int PCP_PWR_VCC_LSB = 3;
  localparam int PCP_PWR_VPP_LSB = 0;
  localparam logic [1:0] PCP_VPP_NONE = 2'h0;
  localparam logic [1:0] PCP_VPP_VCC = 2'h1;
  localparam logic [1:0] PCP_VPP_12V = 2'h2;
  localparam logic [1:0] PCP_VCC_5V = 2'h2;
  localparam logic [1:0] PCP_VCC_3V3 = 2'h3;

  // ****************************************
  // Interrupt and general control layout
  // ****************************************
  localparam logic [7:0] PCP_IGC_CTX = 8'h60;
  localparam int PCP_IGC_RING_BIT = 7;
  localparam int PCP_IGC_RESET_BIT = 6;
  localparam int PCP_IGC_KIND_BIT = 5;
  localparam int PCP_IGC_CSC_BIT = 4;
  localparam logic [3:0] PCP_IRQ_NONE = 4'h0;
  localparam logic [3:0] PCP_IRQ_SMI = 4'h2;
  localparam int PCP_IRQ_LINES = 16;
endpackage : pcp_pkg
`default_nettype wire

/* File: verilog/pcp_power_decode.sv */
// Decoding of the socket power register into supply requests
`default_nettype none
module pcp_power_decode (
  // Register state
  input wire logic original_mode,
  input wire logic [7:0] pwr_value,
  input wire logic system_vcc_level_select,
  // Card presence
  input wire logic card_present,
  // Supply requests
  output logic vcc_5v,
  output logic vcc_3v3,
  output logic vpp_12v,
  output logic vpp_vcc
);
  logic auto_block;
  logic orig_vcc_on;
  logic [1:0] vcc_field;
  logic [1:0] vpp_field;
  logic vcc_on;

  // Auto switching holds power off until both detects show a card present
  assign auto_block = pwr_value[pcp_pkg::PCP_PWR_AUTO_BIT] && !card_present;
  assign orig_vcc_on = pwr_value[pcp_pkg::PCP_PWR_SUPPLY_BIT] && !auto_block;
  assign vcc_field = pwr_value[pcp_pkg::PCP_PWR_VCC_LSB +: 2];
  assign vpp_field = pwr_value[pcp_pkg::PCP_PWR_VPP_LSB +: 2];

  // Level select high picks 3.3 V in the original layout
  assign vcc_5v = original_mode ? (orig_vcc_on && !system_vcc_level_select)
                                : (vcc_field == pcp_pkg::PCP_VCC_5V);
  assign vcc_3v3 = original_mode ? (orig_vcc_on && system_vcc_level_select)
                                 : (vcc_field == pcp_pkg::PCP_VCC_3V3);
  assign vcc_on = vcc_5v || vcc_3v3;

  // Vpp only acts once Vcc is up; reserved codes give 0 V
  assign vpp_12v = vcc_on && (vpp_field == pcp_pkg::PCP_VPP_12V);
  assign vpp_vcc = vcc_on && original_mode && (vpp_field == pcp_pkg::PCP_VPP_VCC);
endmodule : pcp_power_decode
`default_nettype wire

/* File: verilog/pcp_irq_route.sv */
// Routing of status-change and functional card interrupts
`default_nettype none
module pcp_irq_route #(
  parameter int IRQ_LINES = pcp_pkg::PCP_IRQ_LINES
) (
  // Register state
  input wire logic [7:0] igc_value,
  input wire logic diag_route_ctrl,
  // Routing decisions
  output logic csc_to_pci,
  output logic smi_select,
  output logic [IRQ_LINES-1:0] irq_select
);
  logic [3:0] sel;

  if (IRQ_LINES != pcp_pkg::PCP_IRQ_LINES) begin : g_bad_lines
    $error("pcp_irq_route: IRQ_LINES must be 16");
  end

  assign sel = igc_value[3:0];
  // Select code of zero always reaches PCI, for older drivers
  assign csc_to_pci = (sel == pcp_pkg::PCP_IRQ_NONE)
                   || (!diag_route_ctrl && igc_value[pcp_pkg::PCP_IGC_CSC_BIT]);
  assign smi_select = (sel == pcp_pkg::PCP_IRQ_SMI);

  for (genvar i = 0; i < IRQ_LINES; i++) begin : g_irq
    localparam logic [3:0] CODE = 4'(i);
    assign irq_select[i] = (sel == CODE) && (CODE != pcp_pkg::PCP_IRQ_NONE)
                        && (CODE != pcp_pkg::PCP_IRQ_SMI);
  end
endmodule : pcp_irq_route
`default_nettype wire

/* File: verilog/pcp_socket_ctrl.sv */
// Socket power control and interrupt/general control registers
`default_nettype none
module pcp_socket_ctrl #(
  parameter int IRQ_LINES = pcp_pkg::PCP_IRQ_LINES
) (
  // Clock and resets
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic GLOBAL_RESET,
  input wire logic BUS_RESET,
  input wire logic POWER_EVENT_EN,
  // Register port
  input wire logic [11:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  // System configuration
  input wire logic SYSTEM_VCC_LEVEL_SELECT,
  input wire logic DIAG_ROUTE_CTRL,
  input wire logic CARD_IS_32BIT,
  // Card status
  input wire logic CARD_DETECT1_N,
  input wire logic CARD_DETECT2_N,
  input wire logic CARD_READY,
  input wire logic CARD_WRITE_PROTECT,
  input wire logic [1:0] BATTERY_DETECT,
  // Socket power switch
  output logic VCC_5V_EN,
  output logic VCC_3V3_EN,
  output logic VPP_12V_EN,
  output logic VPP_VCC_EN,
  // Card control
  output logic CARD_OUTPUTS_EN,
  output logic CARD_RESET,
  output logic CARD_KIND,
  output logic RING_INDICATE_EN,
  output logic RING_INDICATE,
  // Interrupt routing
  output logic CSC_TO_PCI,
  output logic SMI_SELECT,
  output logic [IRQ_LINES-1:0] IRQ_SELECT
);
  // ****************************************
  // Register state
  // ****************************************
  logic [7:0] pwr_reg;
  logic [7:0] pwr_next;
  logic [7:0] igc_reg;
  logic [7:0] igc_next;
  logic [3:0] rev_reg;
  logic [3:0] rev_next;
  logic [1:0] idspare_reg;
  logic [1:0] idspare_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // ****************************************
  // Decode
  // ****************************************
  logic original_mode;
  logic [7:0] pwr_mask;
  logic [7:0] pwr_ctx;
  logic [7:0] pwr_view;
  logic bus_clear_all;
  logic [7:0] pwr_keep;
  logic [7:0] igc_keep;
  logic wr_pwr;
  logic wr_igc;
  logic wr_ident;
  logic card_present;
  logic vcc_5v;
  logic vcc_3v3;
  logic vpp_12v;
  logic vpp_vcc;
  logic power_off;
  logic csc_to_pci;
  logic smi_select;
  logic [IRQ_LINES-1:0] irq_select;
  logic [7:0] ident_view;
  logic [7:0] ifstat_view;

  if (IRQ_LINES != pcp_pkg::PCP_IRQ_LINES) begin : g_bad_lines
    $error("pcp_socket_ctrl: IRQ_LINES must be 16");
  end

  // Layout picked from the live revision value, no extra latency
  assign original_mode = (rev_reg == pcp_pkg::PCP_REV_ORIGINAL);
  assign pwr_mask = original_mode ? pcp_pkg::PCP_PWR_MASK_ORIG : pcp_pkg::PCP_PWR_MASK_REV;
  assign pwr_ctx = original_mode ? pcp_pkg::PCP_PWR_CTX_ORIG : pcp_pkg::PCP_PWR_CTX_REV;
  assign pwr_view = pwr_reg & pwr_mask;

  // Bus reset spares context bits only while power events are on
  assign bus_clear_all = !POWER_EVENT_EN;
  assign pwr_keep = bus_clear_all ? 8'h00 : pwr_ctx;
  assign igc_keep = bus_clear_all ? 8'h00 : pcp_pkg::PCP_IGC_CTX;

  assign wr_pwr = REG_WR && (REG_ADDR == pcp_pkg::PCP_OFS_PWR);
  assign wr_igc = REG_WR && (REG_ADDR == pcp_pkg::PCP_OFS_IGC);
  assign wr_ident = REG_WR && (REG_ADDR == pcp_pkg::PCP_OFS_IDENT);

  // ****************************************
  // Next-state selection
  // ****************************************
  // Global reset outranks bus reset, which outranks a write
  assign pwr_next = GLOBAL_RESET ? pcp_pkg::PCP_PWR_RESET
                  : BUS_RESET ? (pwr_reg & pwr_keep)
                  : wr_pwr ? (REG_WDATA & pwr_mask)
                  : pwr_reg;
  assign igc_next = GLOBAL_RESET ? pcp_pkg::PCP_IGC_RESET
                  : BUS_RESET ? (igc_reg & igc_keep)
                  : wr_igc ? REG_WDATA
                  : igc_reg;
  // Revision field answers to the global reset and to ident writes, not to bus reset
  assign rev_next = GLOBAL_RESET ? pcp_pkg::PCP_REV_RESET
                  : wr_ident ? REG_WDATA[3:0]
                  : rev_reg;
  assign idspare_next = GLOBAL_RESET ? pcp_pkg::PCP_IDSPARE_RESET
                      : wr_ident ? REG_WDATA[5:4]
                      : idspare_reg;

  // ****************************************
  // Power and routing decode
  // ****************************************
  assign card_present = !CARD_DETECT1_N && !CARD_DETECT2_N;

  pcp_power_decode u_power (
    .original_mode(original_mode),
    .pwr_value(pwr_view),
    .system_vcc_level_select(SYSTEM_VCC_LEVEL_SELECT),
    .card_present(card_present),
    .vcc_5v(vcc_5v),
    .vcc_3v3(vcc_3v3),
    .vpp_12v(vpp_12v),
    .vpp_vcc(vpp_vcc)
  );

  pcp_irq_route #(
    .IRQ_LINES(IRQ_LINES)
  ) u_route (
    .igc_value(igc_reg),
    .diag_route_ctrl(DIAG_ROUTE_CTRL),
    .csc_to_pci(csc_to_pci),
    .smi_select(smi_select),
    .irq_select(irq_select)
  );

  // Vpp cannot be on without Vcc, so Vcc alone decides
  assign power_off = !(vcc_5v || vcc_3v3);

  // ****************************************
  // Read path
  // ****************************************
  assign ident_view = {pcp_pkg::PCP_IFTYPE, idspare_reg, rev_reg};
  assign ifstat_view = {1'b0, power_off, CARD_READY, CARD_WRITE_PROTECT,
                        !CARD_DETECT2_N, !CARD_DETECT1_N, BATTERY_DETECT};
  // Unmapped addresses read zero
  assign rdata_next = !REG_RD ? rdata_reg
                    : (REG_ADDR == pcp_pkg::PCP_OFS_IDENT) ? ident_view
                    : (REG_ADDR == pcp_pkg::PCP_OFS_IFSTAT) ? ifstat_view
                    : (REG_ADDR == pcp_pkg::PCP_OFS_PWR) ? pwr_view
                    : (REG_ADDR == pcp_pkg::PCP_OFS_IGC) ? igc_reg
                    : 8'h00;

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      pwr_reg <= pcp_pkg::PCP_PWR_RESET;
      igc_reg <= pcp_pkg::PCP_IGC_RESET;
      rev_reg <= pcp_pkg::PCP_REV_RESET;
      idspare_reg <= pcp_pkg::PCP_IDSPARE_RESET;
      rdata_reg <= 8'h00;
    end else begin
      pwr_reg <= pwr_next;
      igc_reg <= igc_next;
      rev_reg <= rev_next;
      idspare_reg <= idspare_next;
      rdata_reg <= rdata_next;
    end
  end

  // Outputs follow the registers one cycle later
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      VCC_5V_EN <= 1'b0;
      VCC_3V3_EN <= 1'b0;
      VPP_12V_EN <= 1'b0;
      VPP_VCC_EN <= 1'b0;
      CARD_OUTPUTS_EN <= 1'b0;
      CARD_RESET <= 1'b0;
      CARD_KIND <= 1'b0;
      RING_INDICATE_EN <= 1'b0;
      RING_INDICATE <= 1'b0;
      CSC_TO_PCI <= 1'b0;
      SMI_SELECT <= 1'b0;
      IRQ_SELECT <= '0;
    end else begin
      VCC_5V_EN <= vcc_5v;
      VCC_3V3_EN <= vcc_3v3;
      VPP_12V_EN <= vpp_12v;
      VPP_VCC_EN <= vpp_vcc;
      CARD_OUTPUTS_EN <= pwr_reg[pcp_pkg::PCP_PWR_OE_BIT];
      // A 32-bit card never sees this reset line
      CARD_RESET <= !igc_reg[pcp_pkg::PCP_IGC_RESET_BIT] && !CARD_IS_32BIT;
      CARD_KIND <= igc_reg[pcp_pkg::PCP_IGC_KIND_BIT];
      RING_INDICATE_EN <= igc_reg[pcp_pkg::PCP_IGC_RING_BIT];
      RING_INDICATE <= igc_reg[pcp_pkg::PCP_IGC_RING_BIT] && BATTERY_DETECT[0];
      CSC_TO_PCI <= csc_to_pci;
      SMI_SELECT <= smi_select;
      IRQ_SELECT <= irq_select;
    end
  end

  assign REG_RDATA = rdata_reg;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  a_output_gate: assert property (wr_pwr && !GLOBAL_RESET && !BUS_RESET |-> ##2 CARD_OUTPUTS_EN == $past(REG_WDATA[7], 2))
    else $error("card output enable does not follow written bit 7");
  a_auto_switch: assert property (original_mode && pwr_view[5] && !card_present |=> !VCC_5V_EN && !VCC_3V3_EN)
    else $error("power applied without card present under auto switch");
  a_vcc_original: assert property (original_mode && !pwr_reg[4] |=> !VCC_5V_EN && !VCC_3V3_EN)
    else $error("Vcc on with supply bit clear");
  a_vpp_gated: assert property (!VCC_5V_EN && !VCC_3V3_EN |-> !VPP_12V_EN && !VPP_VCC_EN)
    else $error("Vpp driven while Vcc off");
  a_vcc_revised: assert property (!original_mode && pwr_reg[4:3] == 2'h3 |=> VCC_3V3_EN && !VCC_5V_EN)
    else $error("revised 3.3 V code not decoded");
  a_reserved_read: assert property (REG_RD && REG_ADDR == pcp_pkg::PCP_OFS_PWR
      |=> (REG_RDATA & ~$past(pwr_mask)) == 8'h00)
    else $error("reserved power bits read nonzero");
  a_bus_reset_keep: assert property (POWER_EVENT_EN && BUS_RESET && !GLOBAL_RESET
      |=> igc_reg[6:5] == $past(igc_reg[6:5]) && igc_reg[4:0] == 5'h00)
    else $error("bus reset mishandled context bits");
  a_global_clear: assert property (GLOBAL_RESET |=> pwr_reg == 8'h00 && igc_reg == 8'h00 && rev_reg == 4'h4)
    else $error("global reset did not restore defaults");
  a_card_reset: assert property (!igc_reg[6] && !CARD_IS_32BIT |=> CARD_RESET)
    else $error("card reset not asserted");
  a_csc_pci: assert property (igc_reg[3:0] == 4'h0 |=> CSC_TO_PCI)
    else $error("select zero failed to route to PCI");
  a_csc_diag: assert property (DIAG_ROUTE_CTRL && igc_reg[3:0] != 4'h0 |=> !CSC_TO_PCI)
    else $error("routing bit acted while diagnostic bit set");
  a_smi_select: assert property (igc_reg[3:0] == 4'h2 |=> SMI_SELECT && IRQ_SELECT == '0)
    else $error("SYSTEM_MANAGEMENT_INTERRUPT code mis-decoded");
  a_power_status: assert property (REG_RD && REG_ADDR == pcp_pkg::PCP_OFS_IFSTAT
      |=> REG_RDATA[6] == $past(power_off))
    else $error("power status bit wrong");

  c_orig_mode: cover property (wr_ident && REG_WDATA[3:0] == 4'h2 ##1 VCC_5V_EN);
  c_vpp_12v: cover property (VPP_12V_EN && VCC_3V3_EN);
  c_card_release: cover property (CARD_RESET ##1 !CARD_RESET);
  c_irq_route: cover property (IRQ_SELECT[9] && !CSC_TO_PCI);
endmodule : pcp_socket_ctrl
`default_nettype wire

/* File: dv/pcp_card_model.sv */
// Behavioural model of the card in the socket and its power switch
`default_nettype none
module pcp_card_model (
  // Test control
  input wire logic inserted,
  input wire logic ring,
  // Power switch
  input wire logic vcc_5v_en,
  input wire logic vcc_3v3_en,
  // Card pins
  output logic cd1_n,
  output logic cd2_n,
  output logic ready,
  output logic wp,
  output logic [1:0] bvd
);
  timeunit 1ns;
  timeprecision 1ns;
  wire logic powered = vcc_5v_en | vcc_3v3_en;
  // Detect pins are pulled up, so an empty socket reads high
  assign cd1_n = !inserted;
  assign cd2_n = !inserted;
  // An unpowered card is never ready; write protect reads low, battery detects read low with no card inserted and {1, ring} with one
  assign ready = inserted & powered;
  assign wp = 1'b0;
  assign bvd = inserted ? {1'b1, ring} : 2'h0;
endmodule : pcp_card_model
`default_nettype wire

/* File: dv/tb_top.sv */
// Self-checking bench for the socket power and interrupt control registers
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_count++; $display("unexpected at %0t: got %h exp %h", $time, (g), (e)); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK_SYS = 1'b0;
  logic RST, GLOBAL_RESET, BUS_RESET, POWER_EVENT_EN, REG_WR, REG_RD;
  logic [11:0] REG_ADDR;
  logic [7:0] REG_WDATA, REG_RDATA, d;
  logic SYSTEM_VCC_LEVEL_SELECT, DIAG_ROUTE_CTRL, CARD_IS_32BIT, inserted, ring;
  logic cd1_n, cd2_n, ready, wp;
  logic [1:0] bvd;
  logic VCC_5V_EN, VCC_3V3_EN, VPP_12V_EN, VPP_VCC_EN, CARD_OUTPUTS_EN, CARD_RESET, CARD_KIND;
  logic RING_INDICATE_EN, RING_INDICATE, CSC_TO_PCI, SMI_SELECT;
  logic [15:0] IRQ_SELECT;
  int err_count = 0;
  int total_checks = 0;
  int cycles = 0;

  pcp_socket_ctrl pcp_socket_ctrl_inst (.CLK_SYS(CLK_SYS), .RST(RST), .GLOBAL_RESET(GLOBAL_RESET),
    .BUS_RESET(BUS_RESET), .POWER_EVENT_EN(POWER_EVENT_EN), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .SYSTEM_VCC_LEVEL_SELECT(SYSTEM_VCC_LEVEL_SELECT), .DIAG_ROUTE_CTRL(DIAG_ROUTE_CTRL),
    .CARD_IS_32BIT(CARD_IS_32BIT), .CARD_DETECT1_N(cd1_n), .CARD_DETECT2_N(cd2_n), .CARD_READY(ready),
    .CARD_WRITE_PROTECT(wp), .BATTERY_DETECT(bvd), .VCC_5V_EN(VCC_5V_EN), .VCC_3V3_EN(VCC_3V3_EN),
    .VPP_12V_EN(VPP_12V_EN), .VPP_VCC_EN(VPP_VCC_EN), .CARD_OUTPUTS_EN(CARD_OUTPUTS_EN),
    .CARD_RESET(CARD_RESET), .CARD_KIND(CARD_KIND), .RING_INDICATE_EN(RING_INDICATE_EN),
    .RING_INDICATE(RING_INDICATE), .CSC_TO_PCI(CSC_TO_PCI), .SMI_SELECT(SMI_SELECT), .IRQ_SELECT(IRQ_SELECT));

  pcp_card_model pcp_card_model_inst (.inserted(inserted), .ring(ring), .vcc_5v_en(VCC_5V_EN),
    .vcc_3v3_en(VCC_3V3_EN), .cd1_n(cd1_n), .cd2_n(cd2_n), .ready(ready), .wp(wp), .bvd(bvd));

  always #50 CLK_SYS = ~CLK_SYS;

  // ****************************************
  // Register access tasks, entered at a falling edge
  // ****************************************
  // Outputs derive one edge after the register, so two more edges pass after the write edge before return
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    REG_ADDR = a;
    REG_WDATA = v;
    REG_WR = 1'b1;
    @(negedge CLK_SYS);
    REG_WR = 1'b0;
    repeat (2) @(negedge CLK_SYS);
  endtask : wr

  task automatic chk_rd(input logic [11:0] a, input logic [7:0] e);
    REG_ADDR = a;
    REG_RD = 1'b1;
    @(negedge CLK_SYS);
    REG_RD = 1'b0;
    d = REG_RDATA;
    `CHK(d, e)
  endtask : chk_rd

  task automatic settle();
    repeat (2) @(negedge CLK_SYS);
  endtask : settle

  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done

  // Whole run needs well under a thousand cycles
  always @(posedge CLK_SYS) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      test_done();
    end
  end

  initial begin
    {GLOBAL_RESET, BUS_RESET, POWER_EVENT_EN, REG_WR, REG_RD, ring} = '0;
    {SYSTEM_VCC_LEVEL_SELECT, DIAG_ROUTE_CTRL, CARD_IS_32BIT} = '0;
    REG_ADDR = 12'h000;
    REG_WDATA = 8'h00;
    inserted = 1'b1;
    RST = 1'b1;
    repeat (2) @(negedge CLK_SYS);
    RST = 1'b0;
    @(negedge CLK_SYS);
    chk_rd(12'h802, 8'h00);
    chk_rd(12'h803, 8'h00);
    chk_rd(12'h800, 8'h84);
    chk_rd(12'h801, 8'h4e);
    `CHK({CARD_OUTPUTS_EN, CARD_RESET, CARD_KIND, RING_INDICATE_EN}, 4'h4)
    wr(12'h801, 8'hff);
    chk_rd(12'h801, 8'h4e);
    chk_rd(12'h810, 8'h00);
    // ****************************************
    // Revised layout
    // ****************************************
    wr(12'h802, 8'hff);
    chk_rd(12'h802, 8'h9b);
    for (int i = 0; i < 16; i++) begin
      wr(12'h802, {3'h4, i[3:2], 1'b0, i[1:0]});
      `CHK({CARD_OUTPUTS_EN, VCC_5V_EN, VCC_3V3_EN, VPP_12V_EN, VPP_VCC_EN}, {1'b1, i[3:2] == 2'h2, i[3:2] == 2'h3, i[3] && i[1:0] == 2'h2, 1'b0})
    end
    wr(12'h802, 8'h90);
    chk_rd(12'h801, 8'h2e);
    // ****************************************
    // Original layout, entered with 5 V stored
    // ****************************************
    wr(12'h800, 8'h02);
    chk_rd(12'h800, 8'h82);
    chk_rd(12'h802, 8'h90);
    SYSTEM_VCC_LEVEL_SELECT = 1'b1;
    settle();
    `CHK({VCC_5V_EN, VCC_3V3_EN}, 2'h1)
    wr(12'h802, 8'hff);
    chk_rd(12'h802, 8'hb3);
    for (int i = 0; i < 16; i++) begin
      SYSTEM_VCC_LEVEL_SELECT = i[3];
      wr(12'h802, {3'h4, i[2], 2'h0, i[1:0]});
      `CHK({VCC_5V_EN, VCC_3V3_EN, VPP_12V_EN, VPP_VCC_EN}, {i[2] && !i[3], i[2] && i[3], i[2] && i[1:0] == 2'h2, i[2] && i[1:0] == 2'h1})
    end
    // Card detects steer the supply only when the auto bit is set
    SYSTEM_VCC_LEVEL_SELECT = 1'b0;
    wr(12'h802, 8'hb0);
    inserted = 1'b0;
    settle();
    `CHK(VCC_5V_EN, 1'b0)
    inserted = 1'b1;
    settle();
    `CHK(VCC_5V_EN, 1'b1)
    wr(12'h802, 8'h90);
    inserted = 1'b0;
    settle();
    `CHK(VCC_5V_EN, 1'b1)
    inserted = 1'b1;
    // ****************************************
    // Interrupt routing and card control
    // ****************************************
    for (int i = 0; i < 64; i++) begin
      DIAG_ROUTE_CTRL = i[5];
      wr(12'h803, {3'h0, i[4], i[3:0]});
      `CHK({CSC_TO_PCI, SMI_SELECT}, {i[3:0] == 4'h0 || (i[4] && !i[5]), i[3:0] == 4'h2})
      `CHK(IRQ_SELECT, (i[3:0] == 4'h0 || i[3:0] == 4'h2) ? 16'h0000 : 16'h0001 << i[3:0])
    end
    ring = 1'b1;
    wr(12'h803, 8'he0);
    `CHK({RING_INDICATE_EN, RING_INDICATE, CARD_RESET, CARD_KIND}, 4'hd)
    chk_rd(12'h803, 8'he0);
    wr(12'h803, 8'h80);
    `CHK({RING_INDICATE_EN, RING_INDICATE, CARD_RESET, CARD_KIND}, 4'he)
    ring = 1'b0;
    CARD_IS_32BIT = 1'b1;
    settle();
    `CHK({RING_INDICATE, CARD_RESET}, 2'h0)
    // ****************************************
    // Context bits against bus and global reset
    // ****************************************
    wr(12'h803, 8'hff);
    wr(12'h802, 8'hb3);
    POWER_EVENT_EN = 1'b1;
    BUS_RESET = 1'b1;
    @(negedge CLK_SYS);
    BUS_RESET = 1'b0;
    chk_rd(12'h803, 8'h60);
    chk_rd(12'h802, 8'ha0);
    POWER_EVENT_EN = 1'b0;
    BUS_RESET = 1'b1;
    @(negedge CLK_SYS);
    BUS_RESET = 1'b0;
    chk_rd(12'h803, 8'h00);
    chk_rd(12'h802, 8'h00);
    chk_rd(12'h800, 8'h82);
    wr(12'h803, 8'hff);
    POWER_EVENT_EN = 1'b1;
    GLOBAL_RESET = 1'b1;
    @(negedge CLK_SYS);
    GLOBAL_RESET = 1'b0;
    chk_rd(12'h803, 8'h00);
    chk_rd(12'h800, 8'h84);
    test_done();
  end
endmodule : tb_top
`undef CHK
`default_nettype wire
